// ### include/ssi_pkg.sv
// Constants, register map and types of the status indication block
package ssi_pkg;
	localparam int unsigned CLK_HZ            = 20_000_000;
	localparam int unsigned TICK_SEC          = 1;
	localparam int unsigned TICK_CYCLES       = CLK_HZ * TICK_SEC;
	localparam int unsigned WARMUP_MIN        = 15;
	localparam int unsigned WARMUP_SECONDS    = WARMUP_MIN * 60;
	localparam int unsigned BLINK_HALF_MS     = 500;
	localparam int unsigned BLINK_HALF_CYCLES = (CLK_HZ / 1000) * BLINK_HALF_MS;

	localparam int unsigned REG_W = 16;

	// Register numbers as seen by the bus master
	localparam logic [15:0] ADDR_COMM_TIMEOUT   = 16'h0008;
	localparam logic [15:0] ADDR_TERM_ENABLE    = 16'h0009;
	localparam logic [15:0] ADDR_LIGHT_ACTIVE   = 16'h0023;
	localparam logic [15:0] ADDR_LIGHT_STANDBY  = 16'h0024;
	localparam logic [15:0] ADDR_AMBIENT_LUX    = 16'h0029;
	localparam logic [15:0] ADDR_LIGHT_STATE    = 16'h002A;
	localparam logic [15:0] ADDR_LED_SOURCE     = 16'h004F;

	localparam logic [15:0] RST_COMM_TIMEOUT    = 16'h0000;
	localparam logic [15:0] RST_TERM_ENABLE     = 16'h0000;
	localparam logic [15:0] RST_LIGHT_ACTIVE    = 16'h0000;
	localparam logic [15:0] RST_LIGHT_STANDBY   = 16'h0000;
	localparam logic [15:0] RST_LED_SOURCE      = 16'h0000;

	localparam int unsigned TERM_EN_BIT = 0;

	// Indication source codes
	localparam logic [15:0] SRC_VOC  = 16'h0000;
	localparam logic [15:0] SRC_HUM  = 16'h0001;
	localparam logic [15:0] SRC_TEMP = 16'h0002;

	localparam int unsigned QTY_VOC  = 0;
	localparam int unsigned QTY_HUM  = 1;
	localparam int unsigned QTY_TEMP = 2;
	localparam int unsigned QTY_N    = 3;

	// Light state codes
	localparam logic [15:0] LIGHT_STANDBY = 16'h0000;
	localparam logic [15:0] LIGHT_LOW     = 16'h0001;
	localparam logic [15:0] LIGHT_ACTIVE  = 16'h0002;

	typedef enum logic [1:0] {
		PH_WARM = 2'b01,
		PH_RUN  = 2'b10
	} ssi_phase_t;
endpackage

// ### include/ssi_light_if.sv
// Carrier between the indication top and the light classifier
interface ssi_light_if;
	logic [15:0] lux;
	logic [15:0] activeThr;
	logic [15:0] standbyThr;
	logic [15:0] lightState;

	modport cfg (output lux, output activeThr, output standbyThr, input lightState);
	modport cls (input lux, input activeThr, input standbyThr, output lightState);
endinterface

// ### rtl/ssi_light_class.sv
// Ambient light classifier against standby and active levels
module ssi_light_class (
	input  wire logic clk,
	input  wire logic rstSyncB,
	ssi_light_if.cls  lightIf
);
	logic [15:0] state_reg;
	logic [15:0] state_next;

	always_comb
	begin
		if (lightIf.lux < lightIf.standbyThr)
			state_next = ssi_pkg::LIGHT_STANDBY;   // [R13]
		else if (lightIf.lux > lightIf.activeThr)
			state_next = ssi_pkg::LIGHT_ACTIVE;    // [R14]
		else
			state_next = ssi_pkg::LIGHT_LOW;       // [R15]
	end

	always_ff @(posedge clk or negedge rstSyncB)
	begin
		if (!rstSyncB)
			state_reg <= ssi_pkg::LIGHT_STANDBY;
		else
			state_reg <= state_next;
	end

	assign lightIf.lightState = state_reg;
endmodule

// ### rtl/ssi_status_ind.sv
// Status LED driver, warm-up, timeout and register file of the sensor
//
// Overview of operation
// [R01] First fifteen minutes warm-up, green blinks
// [R02] VOC reading reported zero during warm-up
// [R03] Green steady inside alert min/max limits
// [R04] Yellow steady outside the alert limits, inside measurement range
// [R05] Yellow blinks on nonzero bus timeout expiry
// [R06] Red steady outside measurement range
// [R07] Red blinks when sensor link lost
// [R08] Bootloader: green and yellow alternate
// [R09] Download in bootloader also flashes red
// [R10] Indication source: VOC default, humidity, temperature
// [R11] Lux reading readable in input register
// [R12] Active and standby thresholds writable
// [R13] Below standby gives standby code
// [R14] Above active gives active code
// [R15] Between thresholds gives low-intensity code
// [R16] Termination connected only while enable set
// [R17] Boot over blink over steady, one colour; boot download lights red with green, blink causes can light several
module ssi_status_ind #(
	parameter int unsigned TICK_CYCLES       = ssi_pkg::TICK_CYCLES,
	parameter int unsigned BLINK_HALF_CYCLES = ssi_pkg::BLINK_HALF_CYCLES,
	parameter int unsigned WARMUP_SECONDS    = ssi_pkg::WARMUP_SECONDS
) (
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic              regWrEn,
	input  wire logic              regRdEn,
	input  wire logic [15:0]       regAddr,
	input  wire logic [15:0]       regWrData,
	output logic      [15:0]       regRdData,
	output logic                   regRdValid,
	output logic                   regAddrErr,
	input  wire logic              busActivity,
	input  wire logic [2:0][15:0]  measValue,
	input  wire logic [2:0][15:0]  alertLow,
	input  wire logic [2:0][15:0]  alertHigh,
	input  wire logic [2:0][15:0]  rangeMin,
	input  wire logic [2:0][15:0]  rangeMax,
	input  wire logic [15:0]       ambientLux,
	input  wire logic              sensorLinkLost,
	input  wire logic              bootloaderMode,
	input  wire logic              downloadActive,
	output logic                   ledGreen,
	output logic                   ledYellow,
	output logic                   ledRed,
	output logic                   termEnable,
	output logic [15:0]            vocReported,
	output logic                   warmupActive
);
	// Three colours packed as {red, yellow, green}
	function automatic logic [2:0] rangeColour(
		input logic [15:0] v,
		input logic [15:0] aLo,
		input logic [15:0] aHi,
		input logic [15:0] rLo,
		input logic [15:0] rHi
	);
		logic [2:0] c;
		c = 3'h0;
		if (v < rLo || v > rHi)
			c = 3'h4;                                  // [R06]
		else if (v >= aLo && v <= aHi)
			c = 3'h1;                                  // [R03]
		else
			c = 3'h2;                                  // [R04]
		return c;
	endfunction

	function automatic logic isMapped(input logic [15:0] a);
		return a == ssi_pkg::ADDR_COMM_TIMEOUT || a == ssi_pkg::ADDR_TERM_ENABLE
			|| a == ssi_pkg::ADDR_LIGHT_ACTIVE || a == ssi_pkg::ADDR_LIGHT_STANDBY
			|| a == ssi_pkg::ADDR_AMBIENT_LUX || a == ssi_pkg::ADDR_LIGHT_STATE
			|| a == ssi_pkg::ADDR_LED_SOURCE;
	endfunction

	// Reset release
	logic rstMeta_reg;
	logic rstSyncB;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rstMeta_reg <= 1'b0;
			rstSyncB    <= 1'b0;
		end
		else
		begin
			rstMeta_reg <= 1'b1;
			rstSyncB    <= rstMeta_reg;
		end
	end

	// Timebase: second tick and blink phase
	logic [31:0] tickCnt_reg;
	logic [31:0] tickCnt_next;
	logic        secTick;
	logic [31:0] blinkCnt_reg;
	logic [31:0] blinkCnt_next;
	logic        blinkPhase_reg;
	logic        blinkPhase_next;

	always_comb
	begin
		secTick         = (tickCnt_reg == TICK_CYCLES - 1);
		tickCnt_next    = secTick ? 32'h00000000 : tickCnt_reg + 32'h00000001;
		blinkPhase_next = blinkPhase_reg;
		if (blinkCnt_reg == BLINK_HALF_CYCLES - 1)
		begin
			blinkCnt_next   = 32'h00000000;
			blinkPhase_next = ~blinkPhase_reg;
		end
		else
			blinkCnt_next = blinkCnt_reg + 32'h00000001;
	end

	always_ff @(posedge clk or negedge rstSyncB)
	begin
		if (!rstSyncB)
		begin
			tickCnt_reg    <= 32'h00000000;
			blinkCnt_reg   <= 32'h00000000;
			blinkPhase_reg <= 1'b1;
		end
		else
		begin
			tickCnt_reg    <= tickCnt_next;
			blinkCnt_reg   <= blinkCnt_next;
			blinkPhase_reg <= blinkPhase_next;
		end
	end

	// Warm-up phase
	ssi_pkg::ssi_phase_t phase_reg;
	ssi_pkg::ssi_phase_t phase_next;
	logic [15:0]         warmSec_reg;
	logic [15:0]         warmSec_next;

	always_comb
	begin
		phase_next   = phase_reg;
		warmSec_next = warmSec_reg;
		case (phase_reg)
			ssi_pkg::PH_WARM:
			begin
				if (secTick)
				begin
					warmSec_next = warmSec_reg + 16'h0001;
					if (warmSec_reg == 16'(WARMUP_SECONDS - 1))
						phase_next = ssi_pkg::PH_RUN;     // [R01]
				end
			end
			ssi_pkg::PH_RUN:
				phase_next = ssi_pkg::PH_RUN;
			default:
				phase_next = ssi_pkg::PH_WARM;
		endcase
	end

	always_ff @(posedge clk or negedge rstSyncB)
	begin
		if (!rstSyncB)
		begin
			phase_reg   <= ssi_pkg::PH_WARM;
			warmSec_reg <= 16'h0000;
		end
		else
		begin
			phase_reg   <= phase_next;
			warmSec_reg <= warmSec_next;
		end
	end

	// Holding registers and bus idle timer
	logic [15:0] commTimeout_reg;
	logic [15:0] commTimeout_next;
	logic [15:0] termReg_reg;
	logic [15:0] termReg_next;
	logic [15:0] activeThr_reg;
	logic [15:0] activeThr_next;
	logic [15:0] standbyThr_reg;
	logic [15:0] standbyThr_next;
	logic [15:0] ledSource_reg;
	logic [15:0] ledSource_next;
	logic [15:0] idleSec_reg;
	logic [15:0] idleSec_next;
	logic        timedOut;

	always_comb
	begin
		commTimeout_next = commTimeout_reg;
		termReg_next     = termReg_reg;
		activeThr_next   = activeThr_reg;
		standbyThr_next  = standbyThr_reg;
		ledSource_next   = ledSource_reg;
		if (regWrEn)
		begin
			case (regAddr)
				ssi_pkg::ADDR_COMM_TIMEOUT:  commTimeout_next = regWrData;
				ssi_pkg::ADDR_TERM_ENABLE:   termReg_next     = regWrData;
				ssi_pkg::ADDR_LIGHT_ACTIVE:  activeThr_next   = regWrData;   // [R12]
				ssi_pkg::ADDR_LIGHT_STANDBY: standbyThr_next  = regWrData;   // [R12]
				ssi_pkg::ADDR_LED_SOURCE:    ledSource_next   = regWrData;   // [R10]
				default:                     ledSource_next   = ledSource_reg;
			endcase
		end
		// Own register traffic counts as bus activity
		if (busActivity || regWrEn || regRdEn)
			idleSec_next = 16'h0000;
		else if (secTick && idleSec_reg != 16'hFFFF)
			idleSec_next = idleSec_reg + 16'h0001;
		else
			idleSec_next = idleSec_reg;
		timedOut = (commTimeout_reg != 16'h0000) && (idleSec_reg >= commTimeout_reg);   // [R05]
	end

	always_ff @(posedge clk or negedge rstSyncB)
	begin
		if (!rstSyncB)
		begin
			commTimeout_reg <= ssi_pkg::RST_COMM_TIMEOUT;
			termReg_reg     <= ssi_pkg::RST_TERM_ENABLE;
			activeThr_reg   <= ssi_pkg::RST_LIGHT_ACTIVE;
			standbyThr_reg  <= ssi_pkg::RST_LIGHT_STANDBY;
			ledSource_reg   <= ssi_pkg::RST_LED_SOURCE;
			idleSec_reg     <= 16'h0000;
		end
		else
		begin
			commTimeout_reg <= commTimeout_next;
			termReg_reg     <= termReg_next;
			activeThr_reg   <= activeThr_next;
			standbyThr_reg  <= standbyThr_next;
			ledSource_reg   <= ledSource_next;
			idleSec_reg     <= idleSec_next;
		end
	end

	// Light classification
	ssi_light_if lightIf ();

	assign lightIf.lux        = ambientLux;
	assign lightIf.activeThr  = activeThr_reg;
	assign lightIf.standbyThr = standbyThr_reg;

	ssi_light_class u_light (
		.clk      (clk),
		.rstSyncB (rstSyncB),
		.lightIf  (lightIf.cls)
	);

	// Outputs: LEDs, reported VOC, termination, read port
	logic [1:0]  qtySel;
	logic [2:0]  steady;
	logic        warm;
	logic [2:0]  led_next;
	logic [15:0] voc_next;
	logic [15:0] rdData_next;
	logic [2:0]  led_reg;
	logic [15:0] voc_reg;
	logic        term_reg;
	logic [15:0] rdData_reg;
	logic        rdValid_reg;
	logic        addrErr_reg;
	logic        warm_reg;

	always_comb
	begin
		warm = (phase_reg == ssi_pkg::PH_WARM);
		case (ledSource_reg)                                       // [R10]
			ssi_pkg::SRC_HUM:  qtySel = 2'(ssi_pkg::QTY_HUM);
			ssi_pkg::SRC_TEMP: qtySel = 2'(ssi_pkg::QTY_TEMP);
			default:           qtySel = 2'(ssi_pkg::QTY_VOC);
		endcase
		steady = rangeColour(measValue[qtySel], alertLow[qtySel], alertHigh[qtySel],
			rangeMin[qtySel], rangeMax[qtySel]);
		if (bootloaderMode)                                        // [R17]
		begin
			led_next = {downloadActive & blinkPhase_reg, ~blinkPhase_reg, blinkPhase_reg};   // [R08] [R09]
		end
		else if (warm || timedOut || sensorLinkLost)               // [R17]
		begin
			led_next = {sensorLinkLost & blinkPhase_reg, timedOut & blinkPhase_reg,
				warm & blinkPhase_reg};                            // [R01] [R05] [R07]
		end
		else
			led_next = steady;
		voc_next = warm ? 16'h0000 : measValue[ssi_pkg::QTY_VOC];   // [R02]
		case (regAddr)
			ssi_pkg::ADDR_COMM_TIMEOUT:  rdData_next = commTimeout_reg;
			ssi_pkg::ADDR_TERM_ENABLE:   rdData_next = termReg_reg;
			ssi_pkg::ADDR_LIGHT_ACTIVE:  rdData_next = activeThr_reg;
			ssi_pkg::ADDR_LIGHT_STANDBY: rdData_next = standbyThr_reg;
			ssi_pkg::ADDR_AMBIENT_LUX:   rdData_next = ambientLux;            // [R11]
			ssi_pkg::ADDR_LIGHT_STATE:   rdData_next = lightIf.lightState;    // [R13] [R14] [R15]
			ssi_pkg::ADDR_LED_SOURCE:    rdData_next = ledSource_reg;
			default:                     rdData_next = 16'h0000;
		endcase
		if (!regRdEn)
			rdData_next = 16'h0000;
	end

	always_ff @(posedge clk or negedge rstSyncB)
	begin
		if (!rstSyncB)
		begin
			led_reg     <= 3'h0;
			voc_reg     <= 16'h0000;
			term_reg    <= 1'b0;
			rdData_reg  <= 16'h0000;
			rdValid_reg <= 1'b0;
			addrErr_reg <= 1'b0;
			warm_reg    <= 1'b1;
		end
		else
		begin
			led_reg     <= led_next;
			voc_reg     <= voc_next;
			term_reg    <= termReg_reg[ssi_pkg::TERM_EN_BIT];   // [R16]
			rdData_reg  <= rdData_next;
			rdValid_reg <= regRdEn;
			// Writes to read-only registers are refused too
			addrErr_reg <= (regRdEn && !isMapped(regAddr))
				|| (regWrEn && (!isMapped(regAddr) || regAddr == ssi_pkg::ADDR_AMBIENT_LUX
				|| regAddr == ssi_pkg::ADDR_LIGHT_STATE));
			warm_reg    <= warm;
		end
	end

	assign ledGreen     = led_reg[0];
	assign ledYellow    = led_reg[1];
	assign ledRed       = led_reg[2];
	assign vocReported  = voc_reg;
	assign termEnable   = term_reg;
	assign regRdData    = rdData_reg;
	assign regRdValid   = rdValid_reg;
	assign regAddrErr   = addrErr_reg;
	assign warmupActive = warm_reg;
endmodule

// ### bench/ssi_status_ind_properties.sv
// Port-level properties of the status indication block
module ssi_status_ind_properties (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        regWrEn,
	input wire logic        regRdEn,
	input wire logic [15:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic [15:0] regRdData,
	input wire logic        regRdValid,
	input wire logic        regAddrErr,
	input wire logic [15:0] ambientLux,
	input wire logic        sensorLinkLost,
	input wire logic        bootloaderMode,
	input wire logic        downloadActive,
	input wire logic        ledGreen,
	input wire logic        ledYellow,
	input wire logic        ledRed,
	input wire logic        termEnable,
	input wire logic [15:0] vocReported,
	input wire logic        warmupActive
);
	timeunit 1ns;
	timeprecision 1ns;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	chk_read_answer: assert property (regRdEn |=> regRdValid)
		else $error("read strobe not answered");
	chk_lux_read: assert property (regRdEn && regAddr == ssi_pkg::ADDR_AMBIENT_LUX |=>
		regRdData == $past(ambientLux)) else $error("lux read wrong");
	chk_ro_write: assert property (regWrEn && (regAddr == ssi_pkg::ADDR_AMBIENT_LUX
		|| regAddr == ssi_pkg::ADDR_LIGHT_STATE) |=> regAddrErr) else $error("write to read-only not flagged");
	chk_voc_zero: assert property (warmupActive && $past(warmupActive) |-> vocReported == 16'h0000)
		else $error("reading shown during warm-up");
	chk_term_follow: assert property (regWrEn && regAddr == ssi_pkg::ADDR_TERM_ENABLE |=>
		##1 termEnable == $past(regWrData[0], 2)) else $error("termination not following register");
	chk_boot_alternate: assert property ($past(bootloaderMode) |-> ledGreen != ledYellow)
		else $error("boot colours not alternating");
	chk_boot_red: assert property ($past(bootloaderMode) && !$past(downloadActive) |-> !ledRed)
		else $error("red lit without download");
	chk_one_colour: assert property (!$past(bootloaderMode) && !$past(sensorLinkLost) &&
		!$past(warmupActive) |-> $onehot0({ledGreen, ledYellow, ledRed})) else $error("two colours lit");

	cover property (regRdValid && regAddrErr);
	cover property ($fell(warmupActive));
	cover property (ledRed && ledGreen && !ledYellow);
endmodule

bind ssi_status_ind ssi_status_ind_properties u_chk (.clk(clk), .rst_b(rst_b), .regWrEn(regWrEn),
	.regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
	.regRdValid(regRdValid), .regAddrErr(regAddrErr), .ambientLux(ambientLux),
	.sensorLinkLost(sensorLinkLost), .bootloaderMode(bootloaderMode), .downloadActive(downloadActive),
	.ledGreen(ledGreen), .ledYellow(ledYellow), .ledRed(ledRed), .termEnable(termEnable),
	.vocReported(vocReported), .warmupActive(warmupActive));

// ### bench/ssi_bus_master.sv
// Bus master model issuing register strobes to the indication block
module ssi_bus_master (
	input  wire logic        clk,
	output logic             regWrEn,
	output logic             regRdEn,
	output logic [15:0]      regAddr,
	output logic [15:0]      regWrData,
	output logic             busActivity,
	input  wire logic [15:0] regRdData,
	input  wire logic        regRdValid,
	input  wire logic        regAddrErr
);
	timeunit 1ns;
	timeprecision 1ns;
	int gap = 0;

	initial
	begin
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		regAddr = 16'h0000;
		regWrData = 16'h0000;
		busActivity = 1'b0;
	end

	// Idle bus shows inverted leftovers, so stale values are never mistaken for live ones
	task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic e);
		repeat (gap) @(posedge clk);
		@(posedge clk);
		regWrEn <= w;
		regRdEn <= !w;
		busActivity <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWrEn <= 1'b0;
		regRdEn <= 1'b0;
		busActivity <= 1'b0;
		regAddr <= ~a;
		regWrData <= ~d;
		@(posedge clk);
		q = (regRdValid === !w) ? regRdData : 16'hDEAD;
		e = regAddrErr;
	endtask
endmodule

// ### bench/ssi_status_ind_tb_top.sv
// Self-checking bench of the status indication block
module ssi_status_ind_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic              clk = 1'b0;
	logic              rst_b = 1'b0;
	logic              regWrEn, regRdEn, busActivity, regRdValid, regAddrErr, e;
	logic [15:0]       regAddr, regWrData, regRdData, ambientLux, vocReported, q;
	logic [2:0][15:0]  measValue, alertLow, alertHigh, rangeMin, rangeMax, t;
	logic              sensorLinkLost, bootloaderMode, downloadActive;
	logic              ledGreen, ledYellow, ledRed, termEnable, warmupActive;
	int                mismatches = 0;
	int                compares = 0;
	int                cycles = 0;
	logic [15:0] V[6] = '{16'h0096, 16'h00FA, 16'h0014, 16'h012D, 16'h00C8, 16'h0032};
	logic [15:0] E[6] = '{16'h0001, 16'h0002, 16'h0004, 16'h0004, 16'h0001, 16'h0002};
	logic [15:0] L[5] = '{16'h0032, 16'h0064, 16'h01F4, 16'h03E8, 16'h03E9};
	logic [15:0] C[5] = '{16'h0000, 16'h0001, 16'h0001, 16'h0001, 16'h0002};
	logic [15:0] RW[5] = '{ssi_pkg::ADDR_COMM_TIMEOUT, ssi_pkg::ADDR_TERM_ENABLE,
		ssi_pkg::ADDR_LIGHT_ACTIVE, ssi_pkg::ADDR_LIGHT_STANDBY, ssi_pkg::ADDR_LED_SOURCE};

	always #25 clk = ~clk;

	ssi_status_ind #(.TICK_CYCLES(4), .BLINK_HALF_CYCLES(3), .WARMUP_SECONDS(3)) DUT (.clk(clk),
		.rst_b(rst_b), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
		.regRdData(regRdData), .regRdValid(regRdValid), .regAddrErr(regAddrErr), .busActivity(busActivity),
		.measValue(measValue), .alertLow(alertLow), .alertHigh(alertHigh), .rangeMin(rangeMin),
		.rangeMax(rangeMax), .ambientLux(ambientLux), .sensorLinkLost(sensorLinkLost),
		.bootloaderMode(bootloaderMode), .downloadActive(downloadActive), .ledGreen(ledGreen),
		.ledYellow(ledYellow), .ledRed(ledRed), .termEnable(termEnable), .vocReported(vocReported),
		.warmupActive(warmupActive));

	ssi_bus_master M (.clk(clk), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
		.regWrData(regWrData), .busActivity(busActivity), .regRdData(regRdData),
		.regRdValid(regRdValid), .regAddrErr(regAddrErr));

	task automatic close_out;
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			mismatches++;
			$display("BAD t=%0t run hung", $time);
			close_out;
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		M.acc(1'b1, a, d, q, e);
	endtask

	task automatic rd(input logic [15:0] a, input logic [15:0] x, input logic xe);
		M.acc(1'b0, a, 16'h0000, q, e);
		chk(q, x);
		chk({15'h0000, e}, {15'h0000, xe});
	endtask

	// Mask bits {red,yellow,green}: set bits must toggle over one half period, others stay dark
	task automatic blink(input logic [2:0] m);
		logic [2:0] a;
		a = {ledRed, ledYellow, ledGreen};
		wt(3);
		chk({13'h0000, a ^ {ledRed, ledYellow, ledGreen}}, {13'h0000, m});
		chk({13'h0000, a & ~m}, 16'h0000);
	endtask

	task automatic st(input logic [15:0] x);
		chk({13'h0000, ledRed, ledYellow, ledGreen}, x);
	endtask

	initial
	begin
		measValue = {16'h0096, 16'h0096, 16'h0097};
		alertLow = {3{16'h0064}};
		alertHigh = {3{16'h00C8}};
		rangeMin = {3{16'h0032}};
		rangeMax = {3{16'h012C}};
		ambientLux = 16'h0000;
		sensorLinkLost = 1'b0;
		bootloaderMode = 1'b0;
		downloadActive = 1'b0;
		wt(6);
		rst_b <= 1'b1;
		wt(4);
		chk({15'h0000, warmupActive}, 16'h0001);
		chk(vocReported, 16'h0000);
		blink(3'b001);
		wt(15);
		chk({15'h0000, warmupActive}, 16'h0000);
		chk(vocReported, 16'h0097);
		for (int i = 0; i < 5; i++)
			rd(RW[i], 16'h0000, 1'b0);
		for (int s = 0; s < 3; s++)
		begin
			wr(ssi_pkg::ADDR_LED_SOURCE, s[15:0]);
			for (int k = 0; k < 6; k++)
			begin
				t = {3{16'h00FA}};
				t[s] = V[k];
				measValue <= t;
				wt(3);
				st(E[k]);
			end
		end
		wr(ssi_pkg::ADDR_LED_SOURCE, 16'h0000);
		measValue <= {3{16'h0096}};
		wr(ssi_pkg::ADDR_COMM_TIMEOUT, 16'h0002);
		wt(16);
		blink(3'b010);
		rd(ssi_pkg::ADDR_COMM_TIMEOUT, 16'h0002, 1'b0);
		wt(1);
		st(16'h0001);
		wr(ssi_pkg::ADDR_COMM_TIMEOUT, 16'h0000);
		wt(16);
		st(16'h0001);
		sensorLinkLost <= 1'b1;
		wt(2);
		blink(3'b100);
		bootloaderMode <= 1'b1;
		wt(2);
		blink(3'b011);
		downloadActive <= 1'b1;
		wt(2);
		blink(3'b111);
		chk({15'h0000, ledRed}, {15'h0000, ledGreen});
		sensorLinkLost <= 1'b0;
		bootloaderMode <= 1'b0;
		downloadActive <= 1'b0;
		wt(2);
		st(16'h0001);
		M.gap = 2;
		wr(ssi_pkg::ADDR_LIGHT_ACTIVE, 16'h03E8);
		wr(ssi_pkg::ADDR_LIGHT_STANDBY, 16'h0064);
		rd(ssi_pkg::ADDR_LIGHT_ACTIVE, 16'h03E8, 1'b0);
		rd(ssi_pkg::ADDR_LIGHT_STANDBY, 16'h0064, 1'b0);
		for (int k = 0; k < 5; k++)
		begin
			ambientLux <= L[k];
			wt(2);
			rd(ssi_pkg::ADDR_AMBIENT_LUX, L[k], 1'b0);
			rd(ssi_pkg::ADDR_LIGHT_STATE, C[k], 1'b0);
		end
		M.gap = 0;
		wr(ssi_pkg::ADDR_TERM_ENABLE, 16'h0001);
		wt(2);
		chk({15'h0000, termEnable}, 16'h0001);
		rd(ssi_pkg::ADDR_TERM_ENABLE, 16'h0001, 1'b0);
		wr(ssi_pkg::ADDR_TERM_ENABLE, 16'h0000);
		wt(2);
		chk({15'h0000, termEnable}, 16'h0000);
		rd(16'h0050, 16'h0000, 1'b1);
		wr(ssi_pkg::ADDR_AMBIENT_LUX, 16'h1111);
		chk({15'h0000, e}, 16'h0001);
		rd(ssi_pkg::ADDR_AMBIENT_LUX, 16'h03E9, 1'b0);
		close_out;
	end
endmodule
